// ---- rtl/dfpm_manager.sv ----
// top of the drive fault protection manager
// assumes fault detect inputs are asynchronous levels from sensing logic,
// serial commands arrive as one-cycle pulses from a same-clock decoder
//
// Function
// - brake on fault, disable, servo-off, power-off
// - absolute encoder/parameter alarm: code all off
// - overcurrent or overheat: code 001
// - error counter overflow: code 011
// - overvoltage: code 100
// - overspeed: code 101
// - overload: code 111
// - encoder faults: code 101
// - momentary power loss: code 010
// - one means transistor conducts
// - fault disables power stage, alarm off
// - fault sends message, red on, alarm off
// - code appears with alarm output
// - clear by serial, clear pin, power cycle; the clear pin is honoured only when ABS_ENCODER is set
// - green while powered, red while fault
// - readable history of past faults
// - alarm held during power-on initialisation
module dfpm_manager
   import dfpm_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_HOLD_CYC,
   parameter bit ABS_ENCODER = 1'b1
) (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic [NUM_SRC-1:0] FAULT_DETECT_I,
   input wire logic SERVO_ON_I,
   input wire logic DRIVE_DISABLE_CMD_I,
   input wire logic POWER_GOOD_I,
   input wire logic FAULT_CLEAR_CMD_I,
   input wire logic FAULT_CLEAR_PIN_I,
   input wire logic [HIST_IDX_W-1:0] HIST_IDX_I,
   output logic POWER_STAGE_EN_O,
   output logic DYN_BRAKE_O,
   output logic FAULT_CODE_BIT1_O,
   output logic FAULT_CODE_BIT2_O,
   output logic FAULT_CODE_BIT3_O,
   output logic FAULT_OUT_O,
   output logic SERVO_FAULT_FLAG_OUT_O,
   output logic RED_LED_O,
   output logic GREEN_LED_O,
   output logic MSG_VALID_O,
   output logic [7:0] MSG_ID_O,
   output logic [7:0] HIST_MSG_O,
   output logic [HIST_IDX_W:0] HIST_COUNT_O
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] det_s1, det_s2;
   logic son_s1, son_s2, dis_s1, dis_s2, pg_s1, pg_s2, clr_s1, clr_s2;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         det_s1 <= '0;
         det_s2 <= '0;
         {son_s1, son_s2, dis_s1, dis_s2} <= 4'h0;
         {pg_s1, pg_s2, clr_s1, clr_s2} <= 4'h0;
      end else begin
         det_s1 <= FAULT_DETECT_I;
         det_s2 <= det_s1;
         son_s1 <= SERVO_ON_I;
         son_s2 <= son_s1;
         dis_s1 <= DRIVE_DISABLE_CMD_I;
         dis_s2 <= dis_s1;
         pg_s1 <= POWER_GOOD_I;
         pg_s2 <= pg_s1;
         clr_s1 <= FAULT_CLEAR_PIN_I;
         clr_s2 <= clr_s1;
      end
   end

   // ----------------------------------------------------------------
   // first-fault selection
   // ----------------------------------------------------------------
   // lowest index wins when several arrive in one cycle
   function automatic logic [3:0] first_src(input logic [NUM_SRC-1:0] v);
      logic [3:0] r;
      r = 4'hF;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : first_src

   wire logic any_det = |det_s2;
   wire logic [3:0] new_src = first_src(det_s2);
   logic [2:0] new_code;
   logic [7:0] new_msg;

   dfpm_code_map u_map (
      .src_i(new_src),
      .code_o(new_code),
      .msg_o(new_msg)
   );

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   dfpm_state_t state, next_state;
   logic [INIT_CNT_W-1:0] init_cnt;
   logic [2:0] code;
   logic [7:0] msg;
   logic msg_valid;
   logic clr_pin_d;

   // clear pin honoured only in absolute encoder builds
   wire logic clr_pin_rise = ABS_ENCODER && clr_s2 && !clr_pin_d;
   wire logic clear_evt = FAULT_CLEAR_CMD_I || clr_pin_rise;
   wire logic init_done = (init_cnt >= INIT_CNT_W'(INIT_CYCLES - 1));
   // a detection in the clear cycle re-latches: set wins over clear
   wire logic latch_new = (state == DFPM_RUN) && any_det;
   wire logic relatch = (state == DFPM_FAULT) && clear_evt && any_det;

   always_comb begin
      next_state = state;
      case (state)
         DFPM_INIT: begin
            if (init_done) begin
               next_state = DFPM_RUN;
            end
         end
         DFPM_RUN: begin
            if (any_det) begin
               next_state = DFPM_FAULT;
            end
         end
         DFPM_FAULT: begin
            if (clear_evt && !any_det) begin
               next_state = DFPM_RUN;
            end
         end
         default: next_state = DFPM_INIT;
      endcase
   end

   // power cycle acts as reset, also clearing the fault
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         state <= DFPM_INIT;
         init_cnt <= '0;
         clr_pin_d <= 1'b0;
      end else begin
         state <= next_state;
         clr_pin_d <= clr_s2;
         if (state == DFPM_INIT && !init_done) begin
            init_cnt <= init_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // latched code and message
   // ----------------------------------------------------------------
   // first fault latched
   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         code <= CODE_OFF;
         msg <= MSG_NONE;
         msg_valid <= 1'b0;
      end else begin
         msg_valid <= latch_new || relatch;
         if (latch_new || relatch) begin
            code <= new_code;
            msg <= new_msg;
         end else if (state == DFPM_FAULT && clear_evt) begin
            code <= CODE_OFF;
         end
      end
   end

   // ----------------------------------------------------------------
   // history
   // ----------------------------------------------------------------
   dfpm_fault_if flt ();
   assign flt.log_pulse = latch_new || relatch;
   assign flt.log_msg = new_msg;
   assign flt.rd_idx = HIST_IDX_I;

   dfpm_history u_hist (
      .clk_i(CORE_CLK_I),
      .reset_n_i(RESET_N_I),
      .flt(flt.hist)
   );

   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         HIST_MSG_O <= MSG_NONE;
         HIST_COUNT_O <= '0;
      end else begin
         HIST_MSG_O <= flt.rd_msg;
         HIST_COUNT_O <= flt.count;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   wire logic faulted = (state == DFPM_FAULT);
   wire logic brake = faulted || dis_s2 || !son_s2 || !pg_s2 || (state == DFPM_INIT);

   always_ff @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         DYN_BRAKE_O <= 1'b1;
         POWER_STAGE_EN_O <= 1'b0;
         RED_LED_O <= 1'b0;
         GREEN_LED_O <= 1'b0;
      end else begin
         DYN_BRAKE_O <= brake;
         POWER_STAGE_EN_O <= !brake;
         RED_LED_O <= faulted;
         GREEN_LED_O <= 1'b1;
      end
   end

   // alarm and code move together from flip-flops
   assign FAULT_OUT_O = !(faulted || state == DFPM_INIT);
   assign SERVO_FAULT_FLAG_OUT_O = FAULT_OUT_O;
   assign FAULT_CODE_BIT1_O = code[0];
   assign FAULT_CODE_BIT2_O = code[1];
   assign FAULT_CODE_BIT3_O = code[2];
   assign MSG_VALID_O = msg_valid;
   assign MSG_ID_O = msg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_brake_on_fault: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      faulted |=> DYN_BRAKE_O && !POWER_STAGE_EN_O)
      else $error("brake not applied during fault");

   a_fault_latch: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      (state == DFPM_RUN) && any_det |=> faulted && !FAULT_OUT_O)
      else $error("detection did not latch fault");

   a_fault_holds: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      faulted && !clear_evt |=> faulted && $stable(code))
      else $error("fault released without clear");

   a_clear_works: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      faulted && clear_evt && !any_det |=> state == DFPM_RUN && code == CODE_OFF)
      else $error("clear did not release fault");

   a_overvolt_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_OV) |=> code == CODE_OV)
      else $error("overvoltage code wrong");

   a_overload_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && det_s2[SRC_OL] && !(|det_s2[SRC_OL-1:0]) |=> code == CODE_OL)
      else $error("overload code wrong");

   a_msg_with_red: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new |=> MSG_VALID_O && MSG_ID_O == $past(new_msg) ##1 RED_LED_O)
      else $error("message or red indicator missing");

   a_init_alarm: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      state == DFPM_INIT |-> !FAULT_OUT_O)
      else $error("alarm not held during init");

   a_init_length: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      state == DFPM_INIT && !init_done |=> state == DFPM_INIT)
      else $error("initialisation left early");

   // ----------------------------------------------------------------
   // pin level checks
   // ----------------------------------------------------------------
   // pin view of the code, so the bit order is checked as well
   wire logic [2:0] code_pins = {FAULT_CODE_BIT3_O, FAULT_CODE_BIT2_O, FAULT_CODE_BIT1_O};
   wire logic stop_req = dis_s2 || !son_s2 || !pg_s2;

   a_stop_brake: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      stop_req |=> DYN_BRAKE_O && !POWER_STAGE_EN_O)
      else $error("stop condition did not brake");

   a_stage_vs_brake: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      POWER_STAGE_EN_O |-> !DYN_BRAKE_O)
      else $error("power stage on while braking");

   a_param_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src <= 4'(SRC_PRM) |=> code_pins == CODE_OFF && !FAULT_OUT_O)
      else $error("parameter fault code wrong");

   a_overcur_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_OC) |=> code_pins == CODE_OC)
      else $error("overcurrent code wrong");

   a_overflow_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_OF) |=> code_pins == CODE_OF)
      else $error("overflow code wrong");

   a_overspd_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_OS) |=> code_pins == CODE_OS)
      else $error("overspeed code wrong");

   a_encoder_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_ENC) |=> code_pins == CODE_OS)
      else $error("encoder fault code wrong");

   a_pwr_loss_code: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && new_src == 4'(SRC_PWR) |=> code_pins == CODE_PWR)
      else $error("power loss code wrong");

   a_code_idle: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      !faulted |-> code_pins == CODE_OFF)
      else $error("code outputs conduct without fault");

   a_code_at_alarm: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      $rose(faulted) |-> code_pins == $past(new_code) && !FAULT_OUT_O)
      else $error("code not presented with alarm");

   a_msg_in_fault: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      MSG_VALID_O |-> faulted)
      else $error("message sent outside fault");

   a_pin_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      faulted && clr_pin_rise && !any_det |=> !faulted && code_pins == CODE_OFF)
      else $error("clear pin did not release fault");

   a_red_tracks: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      faulted |=> RED_LED_O)
      else $error("red indicator dark in fault");

   a_red_clears: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      !faulted |=> !RED_LED_O)
      else $error("red indicator lit without fault");

   a_green_on: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      $past(RESET_N_I) |-> GREEN_LED_O)
      else $error("green indicator dark while powered");

   // history saturates, so only count below depth
   a_hist_count: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      flt.log_pulse && int'(flt.count) < HIST_DEPTH |=> int'(flt.count) == int'($past(flt.count)) + 1)
      else $error("history did not log fault");

   a_first_fault: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      latch_new && det_s2[SRC_OF] && !(|det_s2[SRC_OF-1:0]) |=> MSG_ID_O == MSG_OF && code_pins == CODE_OF)
      else $error("first fault not latched");

endmodule : dfpm_manager

// ---- rtl/dfpm_pkg.sv ----
// shared constants and types of the drive fault protection manager
// assumes a single 20 MHz core clock and synchronous active-low reset
package dfpm_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int INIT_HOLD_S = 2;
   localparam int INIT_HOLD_CYC = INIT_HOLD_S * CLK_HZ;
   localparam int INIT_CNT_W = 26;

   // ----------------------------------------------------------------
   // fault sources, in priority order
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 9;
   localparam int SRC_ABS = 0;
   localparam int SRC_PRM = 1;
   localparam int SRC_OC = 2;
   localparam int SRC_OF = 3;
   localparam int SRC_OV = 4;
   localparam int SRC_OS = 5;
   localparam int SRC_OL = 6;
   localparam int SRC_ENC = 7;
   localparam int SRC_PWR = 8;

   // serial message identifiers, one per source
   localparam logic [7:0] MSG_ABS = 8'h00;
   localparam logic [7:0] MSG_PRM = 8'h02;
   localparam logic [7:0] MSG_OC = 8'h10;
   localparam logic [7:0] MSG_OF = 8'h31;
   localparam logic [7:0] MSG_OV = 8'h40;
   localparam logic [7:0] MSG_OS = 8'h51;
   localparam logic [7:0] MSG_OL = 8'h71;
   localparam logic [7:0] MSG_ENC = 8'hC2;
   localparam logic [7:0] MSG_PWR = 8'hF3;
   localparam logic [7:0] MSG_NONE = 8'hFF;

   // code bits {bit3,bit2,bit1}, 1 = transistor conducts
   localparam logic [2:0] CODE_OFF = 3'h0;
   localparam logic [2:0] CODE_OC = 3'h1;
   localparam logic [2:0] CODE_OF = 3'h3;
   localparam logic [2:0] CODE_OV = 3'h4;
   localparam logic [2:0] CODE_OS = 3'h5;
   localparam logic [2:0] CODE_OL = 3'h7;
   localparam logic [2:0] CODE_PWR = 3'h2;

   localparam int HIST_DEPTH = 8;
   localparam int HIST_IDX_W = 3;

   typedef enum logic [1:0] {
      DFPM_INIT,
      DFPM_RUN,
      DFPM_FAULT
   } dfpm_state_t;

endpackage : dfpm_pkg

// ---- rtl/dfpm_fault_if.sv ----
// bundle carrying the latched fault between the manager and its history
// assumes both ends share the core clock
interface dfpm_fault_if;
   import dfpm_pkg::*;
   logic log_pulse;
   logic [7:0] log_msg;
   logic [HIST_IDX_W-1:0] rd_idx;
   logic [7:0] rd_msg;
   logic [HIST_IDX_W:0] count;

   modport mgr (output log_pulse, output log_msg, output rd_idx,
                input rd_msg, input count);
   modport hist (input log_pulse, input log_msg, input rd_idx,
                 output rd_msg, output count);
endinterface : dfpm_fault_if

// ---- rtl/dfpm_history.sv ----
// ring of past fault message identifiers, newest at index 0
// assumes log pulses come from the manager on the same clock
module dfpm_history
   import dfpm_pkg::*;
#(
   parameter int DEPTH = HIST_DEPTH
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   dfpm_fault_if.hist flt
);

   logic [7:0] mem [DEPTH];
   logic [HIST_IDX_W:0] count;

   assign flt.count = count;
   // index 0 is the newest entry
   assign flt.rd_msg = (int'(flt.rd_idx) < DEPTH) ? mem[flt.rd_idx] : MSG_NONE;

   // ----------------------------------------------------------------
   // shift on every logged fault
   // ----------------------------------------------------------------
   // keep fault history
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         count <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= MSG_NONE;
         end
      end else if (flt.log_pulse) begin
         mem[0] <= flt.log_msg;
         for (int i = 1; i < DEPTH; i++) begin
            mem[i] <= mem[i-1];
         end
         if (int'(count) < DEPTH) begin
            count <= count + 1'b1;
         end
      end
   end

endmodule : dfpm_history

// ---- rtl/dfpm_code_map.sv ----
// maps a one-hot-first fault source index to code bits and message id
// pure combinational, no clock
module dfpm_code_map
   import dfpm_pkg::*;
(
   input wire logic [3:0] src_i,
   output logic [2:0] code_o,
   output logic [7:0] msg_o
);

   always_comb begin
      case (src_i)
         4'(SRC_ABS): begin code_o = CODE_OFF; msg_o = MSG_ABS; end
         4'(SRC_PRM): begin code_o = CODE_OFF; msg_o = MSG_PRM; end
         4'(SRC_OC): begin code_o = CODE_OC; msg_o = MSG_OC; end
         4'(SRC_OF): begin code_o = CODE_OF; msg_o = MSG_OF; end
         4'(SRC_OV): begin code_o = CODE_OV; msg_o = MSG_OV; end
         4'(SRC_OS): begin code_o = CODE_OS; msg_o = MSG_OS; end
         4'(SRC_OL): begin code_o = CODE_OL; msg_o = MSG_OL; end
         4'(SRC_ENC): begin code_o = CODE_OS; msg_o = MSG_ENC; end
         4'(SRC_PWR): begin code_o = CODE_PWR; msg_o = MSG_PWR; end
         default: begin code_o = CODE_OFF; msg_o = MSG_NONE; end
      endcase
   end

endmodule : dfpm_code_map

// ---- verification/dfpm_host_model.sv ----
// host controller model: records fault messages and clears latched faults
// assumes the manager's alarm, message pulse and id all change on clk_i
module dfpm_host_model (
   input wire logic clk_i,
   input wire logic fault_out_i,
   input wire logic msg_valid_i,
   input wire logic [7:0] msg_id_i,
   input wire logic [1:0] clear_mode_i,
   input wire logic [7:0] clear_delay_i,
   output logic clear_cmd_o,
   output logic clear_pin_o,
   output logic [7:0] last_msg_o,
   output logic [7:0] n_msg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pending;
   logic [7:0] wait_cnt;
   // host is not power cycled with the drive, so no reset here
   initial begin
      clear_cmd_o = 1'b0;
      clear_pin_o = 1'b0;
      last_msg_o = 8'hFF;
      n_msg_o = 8'h00;
      pending = 1'b0;
      wait_cnt = 8'h00;
   end
   always @(posedge clk_i) begin
      clear_cmd_o <= 1'b0;
      if (msg_valid_i) begin
         last_msg_o <= msg_id_i;
         n_msg_o <= n_msg_o + 8'h01;
         pending <= 1'b1;
         wait_cnt <= 8'h00;
      end else if (fault_out_i) begin
         pending <= 1'b0;
         clear_pin_o <= 1'b0;
         wait_cnt <= 8'h00;
      end else if (pending && clear_mode_i != 2'h0) begin
         wait_cnt <= wait_cnt + 8'h01;
         if (wait_cnt == clear_delay_i) begin
            clear_cmd_o <= (clear_mode_i == 2'h1);
            clear_pin_o <= (clear_mode_i == 2'h2);
         end
      end
   end
endmodule : dfpm_host_model

// ---- verification/test_drive_fault_protection_manager.sv ----
// self-checking bench of the fault protection manager with a host model
// assumes the shortened init period below and the default encoder setting
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
$display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module test_drive_fault_protection_manager
   import dfpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INIT_N = 16;
   logic clk = 1'b0, rst_n = 1'b0, servo_on = 1'b1, dis = 1'b0, pgood = 1'b1;
   logic [NUM_SRC-1:0] det = '0;
   logic [HIST_IDX_W-1:0] hidx = '0;
   logic [1:0] mode = 2'h0;
   logic stage, brake, c1, c2, c3, fout, sflag, red, green, mval, ccmd, cpin;
   logic [7:0] mid, hmsg, last, n_msg, n_before;
   logic [HIST_IDX_W:0] hcnt;
   int errors = 0, n_compared = 0;
   // codes {bit3,bit2,bit1} per source, lowest index first
   logic [2:0] ecode [NUM_SRC] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7, 3'h5, 3'h2};
   logic [7:0] emsg [NUM_SRC] = '{MSG_ABS, MSG_PRM, MSG_OC, MSG_OF, MSG_OV, MSG_OS,
                                  MSG_OL, MSG_ENC, MSG_PWR};
   always #25 clk = ~clk;
   dfpm_manager #(.INIT_CYCLES(INIT_N), .ABS_ENCODER(1'b1)) dfpm_manager_inst (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .FAULT_DETECT_I(det), .SERVO_ON_I(servo_on),
      .DRIVE_DISABLE_CMD_I(dis), .POWER_GOOD_I(pgood), .FAULT_CLEAR_CMD_I(ccmd),
      .FAULT_CLEAR_PIN_I(cpin), .HIST_IDX_I(hidx), .POWER_STAGE_EN_O(stage),
      .DYN_BRAKE_O(brake), .FAULT_CODE_BIT1_O(c1), .FAULT_CODE_BIT2_O(c2),
      .FAULT_CODE_BIT3_O(c3), .FAULT_OUT_O(fout), .SERVO_FAULT_FLAG_OUT_O(sflag),
      .RED_LED_O(red), .GREEN_LED_O(green), .MSG_VALID_O(mval), .MSG_ID_O(mid),
      .HIST_MSG_O(hmsg), .HIST_COUNT_O(hcnt));
   dfpm_host_model dfpm_host_model_inst (
      .clk_i(clk), .fault_out_i(fout), .msg_valid_i(mval), .msg_id_i(mid),
      .clear_mode_i(mode), .clear_delay_i(8'h04), .clear_cmd_o(ccmd), .clear_pin_o(cpin),
      .last_msg_o(last), .n_msg_o(n_msg));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : tick
   task automatic expect_fault(input logic [2:0] code, input logic [7:0] msg);
      `CHK("code", code, {c3, c2, c1})
      `CHK("fault_out", 1'b0, fout)
      `CHK("servo_flag", 1'b0, sflag)
      `CHK("red", 1'b1, red)
      `CHK("brake", 1'b1, brake)
      `CHK("stage", 1'b0, stage)
      `CHK("message", msg, last)
   endtask : expect_fault
   task automatic expect_run();
      `CHK("fault_out", 1'b1, fout)
      `CHK("code", 3'h0, {c3, c2, c1})
      `CHK("red", 1'b0, red)
      `CHK("brake", 1'b0, brake)
      `CHK("stage", 1'b1, stage)
   endtask : expect_run
   // power cycle: also the third way to clear a fault
   task automatic power_cycle();
      rst_n = 1'b0;
      tick(6);
      `CHK("rst_brake", 1'b1, brake)
      `CHK("rst_code", 3'h0, {c3, c2, c1})
      `CHK("rst_red", 1'b0, red)
      `CHK("rst_msg", 8'hFF, mid)
      rst_n = 1'b1;
      tick(INIT_N / 2);
      `CHK("init_alarm", 1'b0, fout)
      `CHK("green", 1'b1, green)
      tick(INIT_N);
      expect_run();
   endtask : power_cycle
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      #5;
      power_cycle();
      for (int s = 0; s < NUM_SRC; s++) begin
         det = NUM_SRC'(1) << s;
         tick(6);
         expect_fault(ecode[s], emsg[s]);
         `CHK("msg_count", 8'(s + 1), n_msg)
         det = '0;
         tick(10);
         `CHK("latched", ecode[s], {c3, c2, c1})
         `CHK("held_brake", 1'b1, brake)
         mode = (s == 4) ? 2'h2 : 2'h1;
         tick(20);
         expect_run();
         mode = 2'h0;
         `CHK("hist_count", (s < 8) ? 4'(s + 1) : 4'h8, hcnt)
         `CHK("hist_new", emsg[s], hmsg)
      end
      hidx = 3'h1;
      tick(2);
      `CHK("hist_old", emsg[7], hmsg)
      // simultaneous faults, then a clear refused while both are still active
      det = (NUM_SRC'(1) << SRC_OL) | (NUM_SRC'(1) << SRC_OF);
      tick(6);
      expect_fault(3'h3, MSG_OF);
      n_before = n_msg;
      mode = 2'h1;
      tick(12);
      `CHK("relatch", 1'b1, n_msg > n_before)
      `CHK("still_fault", 1'b0, fout)
      det = '0;
      tick(20);
      expect_run();
      mode = 2'h0;
      // each of the three stop conditions applies the brake on its own
      for (int k = 0; k < 3; k++) begin
         servo_on = (k != 0);
         dis = (k == 1);
         pgood = (k != 2);
         tick(5);
         `CHK("stop_brake", 1'b1, brake)
         `CHK("no_alarm", 1'b1, fout)
         servo_on = 1'b1;
         dis = 1'b0;
         pgood = 1'b1;
         tick(5);
         `CHK("released", 1'b0, brake)
      end
      det[SRC_OC] = 1'b1;
      tick(6);
      expect_fault(3'h1, MSG_OC);
      det = '0;
      power_cycle();
      tally_and_finish();
   end
   // ---------------------------------------------------------------
   // watchdog, about three times the expected run
   // ---------------------------------------------------------------
   initial begin
      #75000;
      errors++;
      tally_and_finish();
   end
endmodule : test_drive_fault_protection_manager
